// *** rtl/qbp_params.svh ***
/*
  Constants of the quasi-bidirectional port block: register addresses,
  reset values and the per-pin function masks.
  Assumes inclusion by bare name from the pin cell and top-level design files.
*/
`ifndef QBP_PARAMS_SVH
`define QBP_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define QBP_ADDR_PORT_ONE    8'h90
`define QBP_ADDR_PORT_THREE  8'hb0
`define QBP_ADDR_PORT_FOUR   8'hc0
`define QBP_ADDR_SEL_ONE_A   8'h8e
`define QBP_ADDR_SEL_ONE_B   8'h8f
`define QBP_ADDR_SEL_THREE_A 8'h91
`define QBP_ADDR_SEL_FOUR_A  8'h92
`define QBP_ADDR_SEL_FOUR_B  8'h93
`define QBP_SEL_B_PRESENT    3'b101

// ----------------------------------------
// Reset and idle values
// ----------------------------------------
`define QBP_LATCH_RESET      8'hff
`define QBP_SEL_RESET        8'h00
`define QBP_READ_NONE        8'h00
`define QBP_PIN_IDLE         1'b1

// ----------------------------------------
// Pins that take input-only or open-drain use
// ----------------------------------------
`define QBP_ONE_ALT1_INPUT   8'h03
`define QBP_THREE_ALT_INPUT 8'h3c
`define QBP_THREE_ALT_OD    8'hc0
`define QBP_FOUR_ALT1_INPUT 8'h88
`define QBP_FOUR_ALT2_INPUT 8'h03

`endif

// *** rtl/qbp_pkg.sv ***
/*
  Types of the quasi-bidirectional port block.
  Assumes qbp_params.svh on the include path.
*/
package qbp_pkg;

  // ----------------------------------------
  // Pin driver modes and port identities
  // ----------------------------------------
  typedef enum logic [2:0] {
    QBP_MODE_QUASI,
    QBP_MODE_OPEN_DRAIN,
    QBP_MODE_ANALOG,
    QBP_MODE_PUSH_PULL,
    QBP_MODE_INPUT_ONLY
  } qbp_mode_type;

  typedef enum logic [1:0] {
    QBP_PORT_ONE,
    QBP_PORT_THREE,
    QBP_PORT_FOUR
  } qbp_port_type;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    qbp_mode_type mode;
    logic         use_alt;
  } qbp_func_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       rmw;
    logic       bit_op;
    logic [2:0] bit_idx;
    logic [7:0] addr;
    logic [7:0] wdata;
  } qbp_sfr_req_type;

  typedef struct packed {
    logic drive_en;
    logic drive_val;
    logic pull_a;
    logic pull_b;
  } qbp_pad_type;

endpackage : qbp_pkg

// *** rtl/qbp_pin_cell.sv ***
/*
  One port pin: driver mode, one-cycle high-side pulse, pull-up control.
  Assumes pin_level already synchronised to clk by the parent.
*/
`include "qbp_params.svh"

module qbp_pin_cell (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Control
  input  wire qbp_pkg::qbp_func_type func,
  input  wire logic                 latch_bit,
  input  wire logic                 alt_bit,
  input  wire logic                 pin_level,
  // Pad and read path
  output qbp_pkg::qbp_pad_type      pad,
  output logic                      pin_read
);

  // ----------------------------------------
  // Output value and edge detect
  // ----------------------------------------
  logic                 out_val;
  logic                 prev_val;
  logic                 rise;
  qbp_pkg::qbp_pad_type next_pad;

  assign out_val = func.use_alt ? alt_bit : latch_bit;
  assign rise    = out_val & ~prev_val;

  // ----------------------------------------
  // Driver mode selection
  // ----------------------------------------
  always_comb begin
    next_pad = '0;
    case (func.mode)
      qbp_pkg::QBP_MODE_QUASI: begin
        next_pad.drive_en  = ~out_val | rise;
        next_pad.drive_val = out_val;
        next_pad.pull_a    = out_val & pin_level;
        next_pad.pull_b    = out_val;
      end
      qbp_pkg::QBP_MODE_OPEN_DRAIN: begin
        next_pad.drive_en  = ~out_val;
        next_pad.pull_a    = out_val & pin_level;
        next_pad.pull_b    = out_val;
      end
      qbp_pkg::QBP_MODE_PUSH_PULL: begin
        next_pad.drive_en  = 1'b1;
        next_pad.drive_val = out_val;
      end
      qbp_pkg::QBP_MODE_INPUT_ONLY: begin
        next_pad.pull_a    = pin_level;
        next_pad.pull_b    = 1'b1;
      end
      default: begin
        // Analog: every driver and pull-up off
        next_pad = '0;
      end
    endcase
  end

  // Active pull-down masks whatever the outside drives
  assign pin_read = pin_level & ~(pad.drive_en & ~pad.drive_val);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_val <= `QBP_PIN_IDLE;
      pad      <= '{drive_en: 1'b0, drive_val: 1'b0, pull_a: 1'b1, pull_b: 1'b1};
    end else begin
      prev_val <= out_val;
      pad      <= next_pad;
    end
  end

endmodule // qbp_pin_cell

// *** rtl/qbp_top.sv ***
/*
  Three 8-bit quasi-bidirectional ports with their latch and function
  select registers on the core's special-function register port.
  Assumes a core that presents one request per cycle on sfr_req, marks
  reads of read-modify-write instructions with rmw, and pins that are
  resolved outside from pin_out, pin_oe and the pull-up enables.
  Bit accesses carry the bit in wdata[0] and return it in read bit 0.
  Unmapped addresses read as zero and ignore writes.
  Pin levels may change at any time; two flops take them in.
  Alternate-function routing per pin is fixed; the select registers
  only choose between it and the latch, and pick the driver mode.
  Mode switches count as value changes, so one may start a pulse.
  Only port one and port four have a second select register.
*/
// How it works
// - Three independent 8-pin ports, pin-routable.
// - Reset leaves every pin an input.
// - Reset loads all latch bits with one.
// - Latch zero drives pin low, pull-ups off.
// - Latch rising to one pulses high driver.
// - Pulse only on zero-to-one change.
// - After pulse, weak pull-ups hold high.
// - Latch zero makes pin read zero.
// - Strong pull-up drops when pin low.
// - Read-modify-write reads return latch contents.
// - Other reads return pin levels.
// - Bit and byte access to registers.
// - Driver mode follows selected pin function.
// - Latches at 90h, B0h, C0h.
// - Weak pull-up keeps open pins high.
// - Reset clears function select registers.
// - Open drain suppresses the high pulse.
`include "qbp_params.svh"

module qbp_top #(
  parameter int NUM_PORTS  = 3,
  parameter int PORT_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Register port from the core
  input  wire qbp_pkg::qbp_sfr_req_type      sfr_req,
  output logic [PORT_WIDTH-1:0]              sfr_rdata,
  // Pins
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0] pin_in,
  output logic [NUM_PORTS*PORT_WIDTH-1:0]    pin_out,
  output logic [NUM_PORTS*PORT_WIDTH-1:0]    pin_oe,
  output logic [NUM_PORTS*PORT_WIDTH-1:0]    pull_a_en,
  output logic [NUM_PORTS*PORT_WIDTH-1:0]    pull_b_en,
  // Alternate functions
  input  wire logic [NUM_PORTS*PORT_WIDTH-1:0] alt_out,
  output logic [NUM_PORTS*PORT_WIDTH-1:0]    alt_in
);

  localparam int NUM_PINS = NUM_PORTS * PORT_WIDTH;

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [7:0] LATCH_ADDR [NUM_PORTS] = '{
    `QBP_ADDR_PORT_ONE,
    `QBP_ADDR_PORT_THREE,
    `QBP_ADDR_PORT_FOUR
  };

  localparam logic [7:0] SEL_A_ADDR [NUM_PORTS] = '{
    `QBP_ADDR_SEL_ONE_A,
    `QBP_ADDR_SEL_THREE_A,
    `QBP_ADDR_SEL_FOUR_A
  };

  // Port three has no second select; its slot is masked off below
  localparam logic [7:0] SEL_B_ADDR [NUM_PORTS] = '{
    `QBP_ADDR_SEL_ONE_B,
    `QBP_ADDR_SEL_ONE_B,
    `QBP_ADDR_SEL_FOUR_B
  };

  localparam logic [NUM_PORTS-1:0] SEL_B_PRESENT = `QBP_SEL_B_PRESENT;

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Byte write or single-bit write into an existing byte
  function automatic logic [PORT_WIDTH-1:0] apply_write(
    input logic [PORT_WIDTH-1:0]    old_val,
    input qbp_pkg::qbp_sfr_req_type req
  );
    logic [PORT_WIDTH-1:0] res;
    res = req.wdata;
    if (req.bit_op) begin
      res = old_val;
      res[req.bit_idx] = req.wdata[0];
    end
    return res;
  endfunction

  // Bit reads return the chosen bit in bit 0
  function automatic logic [PORT_WIDTH-1:0] bit_view(
    input logic [PORT_WIDTH-1:0]    val,
    input qbp_pkg::qbp_sfr_req_type req
  );
    logic [PORT_WIDTH-1:0] res;
    res = val;
    if (req.bit_op) begin
      res    = '0;
      res[0] = val[req.bit_idx];
    end
    return res;
  endfunction

  // Address compare shared by every register decode
  function automatic logic addr_match(
    input logic [7:0]               reg_addr,
    input qbp_pkg::qbp_sfr_req_type req
  );
    return req.addr == reg_addr;
  endfunction

  // Pin function from the two select bits of one pin
  function automatic qbp_pkg::qbp_func_type decode_func(
    input qbp_pkg::qbp_port_type port,
    input int unsigned           pin,
    input logic                  sel_a,
    input logic                  sel_b
  );
    logic [7:0]           in_one;
    logic [7:0]           in_three;
    logic [7:0]           od_three;
    logic [7:0]           in_four1;
    logic [7:0]           in_four2;
    qbp_pkg::qbp_func_type res;
    // Masks mark pins whose alternate use is input-only or open drain
    in_one   = `QBP_ONE_ALT1_INPUT;
    in_three = `QBP_THREE_ALT_INPUT;
    od_three = `QBP_THREE_ALT_OD;
    in_four1 = `QBP_FOUR_ALT1_INPUT;
    in_four2 = `QBP_FOUR_ALT2_INPUT;
    res.mode    = qbp_pkg::QBP_MODE_QUASI;
    res.use_alt = sel_a;
    if (sel_a) begin
      case (port)
        // Both selects on port one hand the pin to the converter
        qbp_pkg::QBP_PORT_ONE: begin
          if (sel_b) begin
            res.mode = qbp_pkg::QBP_MODE_ANALOG;
          end else if (in_one[pin]) begin
            res.mode = qbp_pkg::QBP_MODE_INPUT_ONLY;
          end
        end
        qbp_pkg::QBP_PORT_THREE: begin
          if (od_three[pin]) begin
            res.mode = qbp_pkg::QBP_MODE_OPEN_DRAIN;
          end else if (in_three[pin]) begin
            res.mode = qbp_pkg::QBP_MODE_INPUT_ONLY;
          end
        end
        qbp_pkg::QBP_PORT_FOUR: begin
          if (!sel_b) begin
            res.mode = in_four1[pin] ? qbp_pkg::QBP_MODE_INPUT_ONLY
                                     : qbp_pkg::QBP_MODE_PUSH_PULL;
          end else if (in_four2[pin]) begin
            res.mode = qbp_pkg::QBP_MODE_INPUT_ONLY;
          end
        end
        default: begin
          res.mode = qbp_pkg::QBP_MODE_QUASI;
        end
      endcase
    end
    return res;
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [PORT_WIDTH-1:0] port_latch [NUM_PORTS];
  logic [PORT_WIDTH-1:0] sel_a      [NUM_PORTS];
  // The port three entry never decodes and stays at its reset value
  logic [PORT_WIDTH-1:0] sel_b      [NUM_PORTS];

  // Two-stage synchroniser on the pins
  logic [NUM_PINS-1:0]   pin_meta;
  logic [NUM_PINS-1:0]   pin_sync;

  // ----------------------------------------
  // Decode and read paths
  // ----------------------------------------
  logic [NUM_PORTS-1:0]  latch_hit;
  logic [NUM_PORTS-1:0]  sel_a_hit;
  logic [NUM_PORTS-1:0]  sel_b_hit;
  logic [PORT_WIDTH-1:0] rd_part    [NUM_PORTS];
  logic [PORT_WIDTH-1:0] rd_acc     [NUM_PORTS+1];
  logic [PORT_WIDTH-1:0] next_rdata;
  logic [NUM_PINS-1:0]   pin_read;
  logic [NUM_PINS-1:0]   latch_flat;
  logic [NUM_PINS-1:0]   sel_a_flat;
  logic [NUM_PINS-1:0]   sel_b_flat;

  // At most one part is non-zero, so an OR chain selects it
  assign rd_acc[0] = `QBP_READ_NONE;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [PORT_WIDTH-1:0] pin_byte;
      logic [PORT_WIDTH-1:0] latch_view;
      logic [PORT_WIDTH-1:0] sel_view;

      assign latch_hit[p] = addr_match(LATCH_ADDR[p], sfr_req);
      assign sel_a_hit[p] = addr_match(SEL_A_ADDR[p], sfr_req);
      assign sel_b_hit[p] = SEL_B_PRESENT[p] && addr_match(SEL_B_ADDR[p], sfr_req);

      assign pin_byte = pin_read[p*PORT_WIDTH +: PORT_WIDTH];

      // Latch for read-modify-write, pins otherwise
      assign latch_view = sfr_req.rmw ? port_latch[p] : pin_byte;

      assign sel_view = sel_a_hit[p] ? sel_a[p]
                      : sel_b_hit[p] ? sel_b[p]
                      : `QBP_READ_NONE;

      assign rd_part[p] = latch_hit[p] ? latch_view : sel_view;
      assign rd_acc[p+1] = rd_acc[p] | rd_part[p];

      assign latch_flat[p*PORT_WIDTH +: PORT_WIDTH] = port_latch[p];
      assign sel_a_flat[p*PORT_WIDTH +: PORT_WIDTH] = sel_a[p];
      assign sel_b_flat[p*PORT_WIDTH +: PORT_WIDTH] = sel_b[p];

      logic [PORT_WIDTH-1:0] next_latch;
      logic [PORT_WIDTH-1:0] next_sel_a;
      logic [PORT_WIDTH-1:0] next_sel_b;
      logic                  latch_we;
      logic                  sel_a_we;
      logic                  sel_b_we;

      // One decoded write strobe per register
      assign latch_we = sfr_req.wr & latch_hit[p];
      assign sel_a_we = sfr_req.wr & sel_a_hit[p];
      assign sel_b_we = sfr_req.wr & sel_b_hit[p];

      // Unwritten registers hold their value
      assign next_latch = latch_we ? apply_write(port_latch[p], sfr_req)
                                   : port_latch[p];
      assign next_sel_a = sel_a_we ? apply_write(sel_a[p], sfr_req) : sel_a[p];
      assign next_sel_b = sel_b_we ? apply_write(sel_b[p], sfr_req) : sel_b[p];

      // Latch register
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          port_latch[p] <= `QBP_LATCH_RESET;
        end else begin
          port_latch[p] <= next_latch;
        end
      end

      // Function select registers
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sel_a[p] <= `QBP_SEL_RESET;
          sel_b[p] <= `QBP_SEL_RESET;
        end else begin
          sel_a[p] <= next_sel_a;
          sel_b[p] <= next_sel_b;
        end
      end
    end
  endgenerate

  // Unmapped addresses fall through as zero
  assign next_rdata = bit_view(rd_acc[NUM_PORTS], sfr_req);

  // ----------------------------------------
  // Pin cells
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      localparam int unsigned           PIN_IDX = i % PORT_WIDTH;
      localparam qbp_pkg::qbp_port_type PORT_ID = qbp_pkg::qbp_port_type'(i / PORT_WIDTH);
      qbp_pkg::qbp_func_type func;
      qbp_pkg::qbp_pad_type  pad;

      // Routing is fixed per pin, so the decode folds to logic on the two select bits
      assign func = decode_func(PORT_ID,
                                PIN_IDX,
                                sel_a_flat[i],
                                sel_b_flat[i]);

      // Each cell registers its own pad controls and last driven value
      qbp_pin_cell u_cell (
        .clk       (clk),
        .rst_n     (rst_n),
        .func      (func),
        .latch_bit (latch_flat[i]),
        .alt_bit   (alt_out[i]),
        .pin_level (pin_sync[i]),
        .pad       (pad),
        .pin_read  (pin_read[i])
      );

      // Pad fields come straight from the cell's flip-flops
      assign pin_out[i]   = pad.drive_val;
      assign pin_oe[i]    = pad.drive_en;
      assign pull_a_en[i] = pad.pull_a;
      assign pull_b_en[i] = pad.pull_b;
    end
  endgenerate

  // Peripherals see the synchronised level, not the raw pin
  assign alt_in = pin_sync;

  // ----------------------------------------
  // Synchroniser and read data
  // ----------------------------------------
  // Only pin_sync is read elsewhere; pin_meta may still be settling
  // Reset to the idle level so no false low reaches the pull-up logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= {NUM_PINS{`QBP_PIN_IDLE}};
      pin_sync <= {NUM_PINS{`QBP_PIN_IDLE}};
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Read data holds until the next read
  // Registered so the core sees a settled byte one edge after rd
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= `QBP_READ_NONE;
    end else if (sfr_req.rd) begin
      sfr_rdata <= next_rdata;
    end
  end

endmodule // qbp_top

// *** tb/qbp_top_asserts.sv ***
/*
  Checker for the port block register port and pads.
  Assumes port one stays a general-purpose port while it is written.
*/
module qbp_top_asserts #(
  parameter int NUM_PORTS  = 3,
  parameter int PORT_WIDTH = 8
) (
  // Clock and reset
  input wire logic                             clk,
  input wire logic                             rst_n,
  // Register port
  input wire qbp_pkg::qbp_sfr_req_type         sfr_req,
  input wire logic [PORT_WIDTH-1:0]            sfr_rdata,
  // Pins
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0]  pin_in,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0]  pin_out,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0]  pin_oe,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0]  pull_a_en,
  input wire logic [NUM_PORTS*PORT_WIDTH-1:0]  pull_b_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire       wr_one = sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == 8'h90;
  wire       rd_one = sfr_req.rd && !sfr_req.bit_op && sfr_req.addr == 8'h90;
  wire [7:0] oe1    = pin_oe[7:0];
  wire [7:0] out1   = pin_out[7:0];
  wire       low1   = oe1 == 8'hff && out1 == 8'h00;
  sequence s_set_from_low;
    wr_one && sfr_req.wdata == 8'hff && low1;
  endsequence
  sequence s_pulse_then_weak;
    oe1 == 8'hff && out1 == 8'hff ##1 oe1 == 8'h00 && pull_b_en[7:0] == 8'hff;
  endsequence
  sequence s_write_then_rmw;
    wr_one ##1 !sfr_req.wr ##1 (rd_one && sfr_req.rmw && !sfr_req.wr);
  endsequence
  a_clear_drives_low: assert property (wr_one && sfr_req.wdata == 8'h00 |-> ##2
    low1 && pull_a_en[7:0] == 8'h00 && pull_b_en[7:0] == 8'h00) else $error("clear not low");
  a_rise_pulses_once: assert property (s_set_from_low |-> ##2 s_pulse_then_weak)
    else $error("no one-cycle pulse");
  a_pulse_one_cycle: assert property (oe1[0] && out1[0] |=> !(oe1[0] && out1[0]))
    else $error("pulse too long");
  a_rewrite_no_pulse: assert property (wr_one && sfr_req.wdata == 8'hff && oe1 == 8'h00
    |-> ##1 (oe1 == 8'h00) [*3]) else $error("pulse on rewrite");
  a_low_masks_read: assert property (rd_one && !sfr_req.rmw && low1 |=> sfr_rdata == 8'h00)
    else $error("driven-low pin not masked");
  a_rmw_reads_latch: assert property (s_write_then_rmw |=>
    sfr_rdata == $past(sfr_req.wdata, 3)) else $error("rmw read not latch");
  a_bit_clear_pin: assert property (sfr_req.wr && sfr_req.bit_op && sfr_req.addr == 8'h90
    && sfr_req.bit_idx == 3'h3 && !sfr_req.wdata[0] |-> ##2 pin_oe[3] && !pin_out[3])
    else $error("bit clear failed");
  a_pull_a_drops: assert property ((!pin_in[0] && !pin_oe[0] && pull_b_en[0]) [*4]
    |-> !pull_a_en[0]) else $error("strong pull-up kept");
  a_unmapped_zero: assert property (sfr_req.rd && sfr_req.addr == 8'h55
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // qbp_top_asserts

bind qbp_top qbp_top_asserts #(.NUM_PORTS(NUM_PORTS), .PORT_WIDTH(PORT_WIDTH)) u_qbp_top_asserts (
  .clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pull_a_en(pull_a_en), .pull_b_en(pull_b_en));

// *** tb/qbp_pin_model.sv ***
/*
  External devices on the 24 port pins.
  Assumes the bench sets ext_en and ext_val; undriven pads float.
*/
module qbp_pin_model #(
  parameter int W = 24
) (
  // Clock
  input  wire logic         clk,
  // Block pads
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] pull_a_en,
  input  wire logic [W-1:0] pull_b_en,
  // Far-side drivers
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  // Resolved levels
  output logic [W-1:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Floating pads change every cycle so no stale level passes
  logic [W-1:0] float_q = '0;
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (pin_oe[k]) pin_in[k] = pin_out[k];
      else if (ext_en[k]) pin_in[k] = ext_val[k];
      else if (pull_a_en[k] || pull_b_en[k]) pin_in[k] = 1'b1;
      else pin_in[k] = float_q[k];
    end
  end
endmodule // qbp_pin_model

// *** tb/tb_top.sv ***
/*
  Bench for the port block: register port tasks and pin scenarios.
  Assumes port one stays general-purpose except in the mode test.
*/
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n;
  qbp_pkg::qbp_sfr_req_type sfr_req;
  logic [7:0]  sfr_rdata;
  logic [23:0] pin_in, pin_out, pin_oe, pull_a_en, pull_b_en, alt_out, ext_en, ext_val;
  logic [23:0] alt_in;
  int          mismatches = 0;
  int          checks = 0;
  qbp_top u_qbp_top (.clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_a_en(pull_a_en),
    .pull_b_en(pull_b_en), .alt_out(alt_out), .alt_in(alt_in));
  qbp_pin_model u_qbp_pin_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_a_en(pull_a_en), .pull_b_en(pull_b_en), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic sfr_wr(input logic [7:0] a, d, input logic b = 1'b0, input logic [2:0] i = 3'h0);
    @(posedge clk);
    sfr_req <= '{1'b1, 1'b0, 1'b0, b, i, a, d};
    @(posedge clk);
    sfr_req.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic m, input logic [7:0] e,
                        input logic b = 1'b0, input logic [2:0] i = 3'h0);
    @(posedge clk);
    sfr_req <= '{1'b0, 1'b1, m, b, i, a, 8'h00};
    @(posedge clk);
    sfr_req.rd <= 1'b0;
    #1;
    `CHK(sfr_rdata, e)
  endtask
  task automatic set_ext(input logic [23:0] en, v);
    @(posedge clk);
    ext_en  <= en;
    ext_val <= v;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset();
    `CHK({pin_oe, ~pull_a_en, ~pull_b_en}, 72'h0)
    rd_chk(8'h90, 1'b1, 8'hff);
    rd_chk(8'hb0, 1'b1, 8'hff);
    rd_chk(8'hc0, 1'b1, 8'hff);
    rd_chk(8'h91, 1'b0, 8'h00);
    rd_chk(8'h90, 1'b0, 8'hff);
  endtask
  task automatic t_drive_low();
    set_ext(24'h0000ff, 24'h0000ff);
    sfr_wr(8'h90, 8'h00);
    tick(1);
    `CHK({pin_oe[7:0], pin_out[7:0], pull_a_en[7:0] | pull_b_en[7:0]}, 24'hff0000)
    rd_chk(8'h90, 1'b0, 8'h00);
    set_ext(24'h0, 24'h0);
    sfr_wr(8'h90, 8'hff);
    tick(1);
    `CHK({pin_oe[7:0], pin_out[7:0]}, 16'hffff)
    tick(1);
    `CHK({pin_oe[7:0], pull_b_en[7:0]}, 16'h00ff)
    sfr_wr(8'h90, 8'hff);
    rd_chk(8'h90, 1'b1, 8'hff);
    `CHK(pin_oe[7:0], 8'h00)
  endtask
  task automatic t_pin_read();
    set_ext(24'h00ffff, 24'h005a5a);
    rd_chk(8'hb0, 1'b0, 8'hff);
    tick(4);
    `CHK(pull_a_en[15:0], 16'h5a5a)
    `CHK(alt_in[15:0], 16'h5a5a)
    rd_chk(8'h90, 1'b0, 8'h5a);
    rd_chk(8'hb0, 1'b1, 8'hff);
    set_ext(24'h0, 24'h0);
    tick(4);
    `CHK(pull_a_en[15:0], 16'hffff)
  endtask
  task automatic t_bit_ops();
    sfr_wr(8'h90, 8'h00, 1'b1, 3'h3);
    tick(1);
    `CHK({pin_oe[3], pin_out[3], pin_oe[2]}, 3'b100)
    rd_chk(8'h90, 1'b1, 8'hf7);
    rd_chk(8'h90, 1'b0, 8'h00, 1'b1, 3'h3);
    rd_chk(8'h90, 1'b0, 8'h01, 1'b1, 3'h4);
    sfr_wr(8'h90, 8'h01, 1'b1, 3'h3);
    tick(1);
    `CHK({pin_oe[3], pin_out[3]}, 2'b11)
    sfr_wr(8'h55, 8'h00);
    rd_chk(8'h55, 1'b0, 8'h00);
  endtask
  task automatic t_modes();
    sfr_wr(8'h91, 8'hc0);
    sfr_wr(8'h92, 8'hff);
    tick(2);
    `CHK({pin_oe[15:14], pin_out[15:14]}, 4'b1100)
    `CHK({pin_oe[23:16], pin_out[23:16] & 8'h77}, 16'h7700)
    @(posedge clk);
    alt_out <= 24'hffc000;
    for (int k = 0; k < 3; k++) begin
      tick(1);
      `CHK(pin_oe[15:14], 2'b00)
    end
    `CHK({pin_oe[15:14], pin_oe[23:16], pin_out[23:16] & 8'h77}, 18'h07777)
    sfr_wr(8'h8e, 8'hff);
    sfr_wr(8'h8f, 8'hff);
    tick(2);
    `CHK(pin_oe[7:0] | pull_a_en[7:0] | pull_b_en[7:0], 8'h00)
    sfr_wr(8'h8e, 8'h00);
    sfr_wr(8'h91, 8'h00);
    sfr_wr(8'h92, 8'h00);
    tick(3);
    `CHK({pin_oe, ~pull_b_en}, 48'h0)
  endtask
  initial begin
    rst_n   = 1'b0;
    sfr_req = '0;
    alt_out = '0;
    ext_en  = '0;
    ext_val = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    t_reset();
    t_drive_low();
    t_pin_read();
    t_bit_ops();
    t_modes();
    conclude();
  end
  // Generous bound: the sequence needs well under a thousand cycles
  initial begin
    #50us;
    mismatches++;
    conclude();
  end
endmodule // tb_top
